// file: shared/lcdd_pkg.sv
package lcdd_pkg;

    // ****************************************************************
    // register map (indices; byte address is four times the index)
    // ****************************************************************
    localparam int unsigned     AXI_ADDR_W         = 14;
    localparam int unsigned     IDX_W              = 12;
    localparam logic [11:0]     IDX_SUPPLY_DUTY    = 12'h0D0;
    localparam logic [11:0]     IDX_FORCE_BLANK    = 12'h0D1;
    localparam logic [11:0]     IDX_CONTRAST       = 12'h0D2;
    localparam logic [3:0]      DMEM_PAGE          = 4'hA;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int unsigned     BIT_SUPPLY_ON      = 0;
    localparam int unsigned     BIT_REF_SELECT     = 2;
    localparam int unsigned     BIT_DUTY_SELECT    = 3;
    localparam int unsigned     BIT_FORCE_ON       = 1;
    localparam int unsigned     BIT_FORCE_OFF      = 2;
    localparam logic [3:0]      CONTRAST_RST       = 4'h0;
    localparam logic [3:0]      CONTRAST_EXT       = 4'h0;

    // ****************************************************************
    // display geometry
    // ****************************************************************
    localparam int unsigned     NUM_COMMONS        = 16;
    localparam int unsigned     NUM_SEGMENTS       = 64;
    localparam int unsigned     DMEM_WORDS         = 256;
    localparam logic [3:0]      LAST_COM_16        = 4'hF;
    localparam logic [3:0]      LAST_COM_8         = 4'h7;

    // ****************************************************************
    // low-speed clock periods per frame (frame rate = f / ticks)
    // ****************************************************************
    localparam logic [11:0]     TICKS_32K768       = 12'h400;
    localparam logic [11:0]     TICKS_38K4         = 12'h400;
    localparam logic [11:0]     TICKS_76K8         = 12'h800;
    localparam logic [11:0]     TICKS_50K          = 12'h640;

    // ****************************************************************
    // bus answers
    // ****************************************************************
    localparam logic [1:0]      RESP_OKAY          = 2'h0;
    localparam logic [1:0]      RESP_SLVERR        = 2'h2;

    typedef enum logic [1:0] {
        LCDD_OSC_32K768 = 2'h0,
        LCDD_OSC_38K4   = 2'h1,
        LCDD_OSC_50K    = 2'h2,
        LCDD_OSC_76K8   = 2'h3
    } lcdd_osc_t;

    typedef enum logic [1:0] {
        LCDD_WR_IDLE = 2'b01,
        LCDD_WR_RESP = 2'b10
    } lcdd_wr_state_t;

    typedef struct packed {
        logic       duty_select;
        logic       reference_level_select;
        logic       lcd_supply_on;
        logic       force_all_off;
        logic       force_all_on;
        logic [3:0] contrast_code;
    } lcdd_ctrl_t;

endpackage

// file: hdl/lcdd_top.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - sixteen commons, sixty-four segments, 1024 dots
// - frame rate fixed per low-speed clock option
// - supply-on bit enables drive levels
// - reference select: 1 second, 0 first
// - force-all-on lights every segment
// - force-all-off blanks every segment
// - all-on wins over all-off
// - both force bits clear shows memory
// - duty bit: 1 eighth duty, 0 sixteenth
// - eighth duty outputs commons 0-7 only
// - memory bit 1 dot on, 0 off
// - display memory sits in page 0AH
// - memory read/write, unused words general storage
// - four-bit contrast code, sixteen levels
// - contrast ignored with external drive levels
// - D0H: duty, reference, zero, supply-on
// - D1H: zero, all-off, all-on, zero
// - contrast code at D2H bits 3-0
module lcdd_top #(
    parameter bit EXT_SUPPLY = 1'b0
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_lsclk_tick,
    input  wire lcdd_pkg::lcdd_osc_t           i_osc_sel,
    input  wire logic [lcdd_pkg::AXI_ADDR_W-1:0] i_awaddr,
    input  wire logic                          i_awvalid,
    output var  logic                          o_awready,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic [3:0]                    i_wstrb,
    input  wire logic                          i_wvalid,
    output var  logic                          o_wready,
    output var  logic [1:0]                    o_bresp,
    output var  logic                          o_bvalid,
    input  wire logic                          i_bready,
    input  wire logic [lcdd_pkg::AXI_ADDR_W-1:0] i_araddr,
    input  wire logic                          i_arvalid,
    output var  logic                          o_arready,
    output var  logic [31:0]                   o_rdata,
    output var  logic [1:0]                    o_rresp,
    output var  logic                          o_rvalid,
    input  wire logic                          i_rready,
    output var  logic [15:0]                   o_common_outputs,
    output var  logic [63:0]                   o_segment_outputs,
    output var  logic                          o_lcd_supply_on,
    output var  logic                          o_reference_level_select,
    output var  logic [3:0]                    o_contrast_code
);
    import lcdd_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [11:0] frame_ticks(input lcdd_osc_t osc);
        case (osc)
            LCDD_OSC_32K768: frame_ticks = TICKS_32K768;
            LCDD_OSC_38K4:   frame_ticks = TICKS_38K4;
            LCDD_OSC_50K:    frame_ticks = TICKS_50K;
            LCDD_OSC_76K8:   frame_ticks = TICKS_76K8;
            default:         frame_ticks = TICKS_32K768;
        endcase
    endfunction

    function automatic logic [11:0] addr_idx(input logic [AXI_ADDR_W-1:0] a);
        addr_idx = a[AXI_ADDR_W-1:2];
    endfunction

    initial begin
        if (NUM_COMMONS * NUM_SEGMENTS != 1024 || DMEM_WORDS != 256) begin
            $error("lcdd_top: geometry not supported");
        end
    end

    // ****************************************************************
    // state
    // ****************************************************************
    lcdd_ctrl_t          ctrl_r;
    logic [3:0]          dmem [0:DMEM_WORDS-1];
    lcdd_wr_state_t      wr_state_r;
    logic                aw_held_r;
    logic                w_held_r;
    logic [IDX_W-1:0]    aw_idx_r;
    logic [31:0]         wdata_r;
    logic                wstrb0_r;
    logic [11:0]         tick_cnt_r;
    logic [3:0]          com_idx_r;
    logic [63:0]         row_bits;

    // ****************************************************************
    // write channel capture, either order
    // ****************************************************************
    wire                 aw_take    = i_awvalid && o_awready;
    wire                 w_take     = i_wvalid && o_wready;
    wire                 aw_have    = aw_held_r || aw_take;
    wire                 w_have     = w_held_r || w_take;
    wire                 wr_fire    = (wr_state_r == LCDD_WR_IDLE) && aw_have && w_have;
    wire [IDX_W-1:0]     wr_idx     = aw_held_r ? aw_idx_r : addr_idx(i_awaddr);
    wire [31:0]          wr_data    = w_held_r ? wdata_r : i_wdata;
    wire                 wr_lane0   = w_held_r ? wstrb0_r : i_wstrb[0];
    wire                 wr_is_dmem = (wr_idx[11:8] == DMEM_PAGE);
    wire                 wr_is_d0   = (wr_idx == IDX_SUPPLY_DUTY);
    wire                 wr_is_d1   = (wr_idx == IDX_FORCE_BLANK);
    wire                 wr_is_d2   = (wr_idx == IDX_CONTRAST);
    wire                 wr_mapped  = wr_is_dmem || wr_is_d0 || wr_is_d1 || wr_is_d2;
    wire                 wr_commit  = wr_fire && wr_lane0;
    wire                 aw_held_nxt = wr_fire ? 1'b0 : aw_have;
    wire                 w_held_nxt  = wr_fire ? 1'b0 : w_have;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_idx_r  <= 12'h000;
            wdata_r   <= 32'h0000_0000;
            wstrb0_r  <= 1'b0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            if (aw_take) begin
                aw_idx_r <= addr_idx(i_awaddr);
            end
            if (w_take) begin
                wdata_r  <= i_wdata;
                wstrb0_r <= i_wstrb[0];
            end
        end
    end

    // ****************************************************************
    // write response
    // ****************************************************************
    lcdd_wr_state_t wr_state_nxt;
    always_comb begin
        case (wr_state_r)
            LCDD_WR_IDLE: wr_state_nxt = wr_fire ? LCDD_WR_RESP : LCDD_WR_IDLE;
            LCDD_WR_RESP: wr_state_nxt = i_bready ? LCDD_WR_IDLE : LCDD_WR_RESP;
            default:      wr_state_nxt = LCDD_WR_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_state_r <= LCDD_WR_IDLE;
            o_bvalid   <= 1'b0;
            o_bresp    <= RESP_OKAY;
            o_awready  <= 1'b1;
            o_wready   <= 1'b1;
        end else begin
            wr_state_r <= wr_state_nxt;
            o_bvalid   <= (wr_state_nxt == LCDD_WR_RESP);
            // readies registered: same value the idle state would give next cycle
            o_awready  <= (wr_state_nxt == LCDD_WR_IDLE) && !aw_held_nxt;
            o_wready   <= (wr_state_nxt == LCDD_WR_IDLE) && !w_held_nxt;
            if (wr_fire) begin
                o_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ****************************************************************
    // control words
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= '{default: 1'b0, contrast_code: CONTRAST_RST};
        end else if (wr_commit) begin
            if (wr_is_d0) begin
                ctrl_r.duty_select            <= wr_data[BIT_DUTY_SELECT];
                ctrl_r.reference_level_select <= wr_data[BIT_REF_SELECT];
                ctrl_r.lcd_supply_on          <= wr_data[BIT_SUPPLY_ON];
            end
            if (wr_is_d1) begin
                ctrl_r.force_all_off <= wr_data[BIT_FORCE_OFF];
                ctrl_r.force_all_on  <= wr_data[BIT_FORCE_ON];
            end
            if (wr_is_d2) begin
                ctrl_r.contrast_code <= wr_data[3:0];
            end
        end
    end

    // ****************************************************************
    // display memory, no reset
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (wr_commit && wr_is_dmem) begin
            dmem[wr_idx[7:0]] <= wr_data[3:0];
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    wire [IDX_W-1:0] rd_idx     = addr_idx(i_araddr);
    wire             rd_take    = i_arvalid && o_arready;
    wire             rd_is_dmem = (rd_idx[11:8] == DMEM_PAGE);
    wire             rd_is_d0   = (rd_idx == IDX_SUPPLY_DUTY);
    wire             rd_is_d1   = (rd_idx == IDX_FORCE_BLANK);
    wire             rd_is_d2   = (rd_idx == IDX_CONTRAST);
    wire             rd_mapped  = rd_is_dmem || rd_is_d0 || rd_is_d1 || rd_is_d2;
    wire [3:0]       rd_d0      = {ctrl_r.duty_select, ctrl_r.reference_level_select,
                                   1'b0, ctrl_r.lcd_supply_on};
    wire [3:0]       rd_d1      = {1'b0, ctrl_r.force_all_off, ctrl_r.force_all_on, 1'b0};
    wire [3:0]       rd_nib     = rd_is_dmem ? dmem[rd_idx[7:0]] :
                                  rd_is_d0   ? rd_d0 :
                                  rd_is_d1   ? rd_d1 :
                                  rd_is_d2   ? ctrl_r.contrast_code : 4'h0;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= RESP_OKAY;
        end else if (rd_take) begin
            o_rvalid  <= 1'b1;
            o_arready <= 1'b0;
            o_rdata   <= {28'h000_0000, rd_nib};
            o_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // common scan
    // ****************************************************************
    wire [11:0] slot_len  = ctrl_r.duty_select ? (frame_ticks(i_osc_sel) >> 3)
                                               : (frame_ticks(i_osc_sel) >> 4);
    wire [3:0]  last_com  = ctrl_r.duty_select ? LAST_COM_8 : LAST_COM_16;
    // >= so a slot shortened by an option change ends at once, no counter wrap
    wire        slot_end  = i_lsclk_tick && (tick_cnt_r >= slot_len - 12'h001);
    wire        com_over  = (com_idx_r > last_com);
    wire [3:0]  com_idx_nxt = com_over ? 4'h0 :
                              !slot_end ? com_idx_r :
                              (com_idx_r == last_com) ? 4'h0 : com_idx_r + 4'h1;
    wire [11:0] tick_cnt_nxt = slot_end ? 12'h000 :
                               i_lsclk_tick ? tick_cnt_r + 12'h001 : tick_cnt_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_r <= 12'h000;
            com_idx_r  <= 4'h0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            com_idx_r  <= com_idx_nxt;
        end
    end

    // ****************************************************************
    // row fetch: word {common, segment/4}, bit = segment mod 4
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_SEGMENTS / 4; g++) begin : g_row
            assign row_bits[4*g +: 4] = dmem[{com_idx_r, 4'(g)}];
        end
    endgenerate

    // ****************************************************************
    // panel drive
    // ****************************************************************
    wire [63:0] seg_view = ctrl_r.force_all_on  ? {64{1'b1}} :
                           ctrl_r.force_all_off ? {64{1'b0}} :
                           row_bits;
    wire [15:0] com_view = 16'h0001 << com_idx_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_common_outputs         <= 16'h0000;
            o_segment_outputs        <= 64'h0000_0000_0000_0000;
            o_lcd_supply_on          <= 1'b0;
            o_reference_level_select <= 1'b0;
            o_contrast_code          <= CONTRAST_RST;
        end else begin
            o_common_outputs         <= ctrl_r.lcd_supply_on ? com_view : 16'h0000;
            o_segment_outputs        <= ctrl_r.lcd_supply_on ? seg_view : 64'h0;
            o_lcd_supply_on          <= ctrl_r.lcd_supply_on;
            o_reference_level_select <= ctrl_r.reference_level_select;
            o_contrast_code          <= EXT_SUPPLY ? CONTRAST_EXT : ctrl_r.contrast_code;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_force_on_wins: assert property (
        ctrl_r.lcd_supply_on && ctrl_r.force_all_on |=> o_segment_outputs == {64{1'b1}})
        else $error("all-on not shown");
    a_force_off_blank: assert property (
        ctrl_r.lcd_supply_on && !ctrl_r.force_all_on && ctrl_r.force_all_off
        |=> o_segment_outputs == 64'h0)
        else $error("all-off not shown");
    a_normal_shows_mem: assert property (
        ctrl_r.lcd_supply_on && !ctrl_r.force_all_on && !ctrl_r.force_all_off
        |=> o_segment_outputs == $past(row_bits))
        else $error("segments differ from memory row");
    a_supply_off_idle: assert property (
        !ctrl_r.lcd_supply_on |=> o_common_outputs == 16'h0000 && o_segment_outputs == 64'h0)
        else $error("drive active while supply off");
    a_common_one_hot: assert property (
        ctrl_r.lcd_supply_on |=> $onehot(o_common_outputs))
        else $error("common select not one-hot");
    a_eighth_duty_range: assert property (
        ctrl_r.duty_select && $past(ctrl_r.duty_select) |-> com_idx_r < 4'h8)
        else $error("common beyond 7 in eighth duty");
    a_slot_advance: assert property (
        slot_end && !com_over |=> com_idx_r != $past(com_idx_r) && tick_cnt_r == 12'h000)
        else $error("slot did not advance");
    a_ctrl_write_d0: assert property (
        wr_commit && wr_is_d0 |=> ctrl_r.lcd_supply_on == $past(wr_data[BIT_SUPPLY_ON])
                               ##1 o_lcd_supply_on == $past(wr_data[BIT_SUPPLY_ON], 2))
        else $error("supply bit write lost");
    a_read_latency: assert property (
        rd_take |=> o_rvalid && o_rdata[31:4] == 28'h000_0000)
        else $error("read answer late or wide");
    a_write_resp_hold: assert property (
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_ref_select_out: assert property (
        o_reference_level_select == $past(ctrl_r.reference_level_select))
        else $error("reference select not shown");
    a_supply_out: assert property (
        o_lcd_supply_on == $past(ctrl_r.lcd_supply_on))
        else $error("supply bit not shown");
    a_contrast_out: assert property (
        o_contrast_code == (EXT_SUPPLY ? CONTRAST_EXT : $past(ctrl_r.contrast_code)))
        else $error("contrast code not shown");
    a_dmem_write: assert property (
        wr_commit && wr_is_dmem |=> dmem[$past(wr_idx[7:0])] == $past(wr_data[3:0]))
        else $error("memory word not written");
    a_sixteenth_wrap: assert property (
        !ctrl_r.duty_select && slot_end && com_idx_r == LAST_COM_16 |=> com_idx_r == 4'h0)
        else $error("sixteenth duty did not wrap");
    a_duty_restart: assert property (
        com_over |=> com_idx_r == 4'h0)
        else $error("common beyond range not restarted");
    a_com_hold: assert property (
        !slot_end && !com_over |=> com_idx_r == $past(com_idx_r))
        else $error("common moved inside slot");
    a_common_scan: assert property (
        ctrl_r.lcd_supply_on |=> o_common_outputs == (16'h0001 << $past(com_idx_r)))
        else $error("wrong common driven");
    a_write_refused: assert property (
        o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (
        o_rvalid |-> !o_arready)
        else $error("read taken while data pending");
    a_d0_read_zero: assert property (
        rd_take && rd_is_d0 |=> o_rdata[1] == 1'b0)
        else $error("supply word zero bit set");
    a_d1_read_zero: assert property (
        rd_take && rd_is_d1 |=> o_rdata[3] == 1'b0 && o_rdata[0] == 1'b0)
        else $error("force word zero bits set");

    c_force_both: cover property (ctrl_r.force_all_on && ctrl_r.force_all_off);
    c_eighth_wrap: cover property (ctrl_r.duty_select && slot_end && com_idx_r == LAST_COM_8);
    c_dmem_write: cover property (wr_commit && wr_is_dmem);
    c_unmapped_read: cover property (rd_take && !rd_mapped);
    c_sixteenth_wrap: cover property (!ctrl_r.duty_select && slot_end && com_idx_r == LAST_COM_16);

endmodule
`default_nettype wire

// file: verif/lcdd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// passive panel: commons driven per frame
// ****************************************
module lcdd_panel_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_common_outputs,
    output var  logic [15:0] o_frame_seen,
    output var  logic        o_multi_common
);
    logic [15:0] acc_r;
    logic        prev_r;

    initial begin
        acc_r = 16'h0000;
        prev_r = 1'b0;
        o_frame_seen = 16'h0000;
        o_multi_common = 1'b0;
    end

    // a frame starts at the rise of common 0
    always @(posedge i_clk) begin
        prev_r <= i_common_outputs[0];
        if (i_common_outputs[0] && !prev_r) begin
            o_frame_seen <= acc_r;
            acc_r        <= i_common_outputs;
        end else begin
            acc_r <= acc_r | i_common_outputs;
        end
        if ($countones(i_common_outputs) > 1) begin
            o_multi_common <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: verif/lcdd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcdd_top_tb;
    import lcdd_pkg::*;
    localparam logic [13:0] A_D0 = 14'h0340, A_D1 = 14'h0344, A_D2 = 14'h0348;
    localparam logic [13:0] A_MEM = 14'h2800, A_BAD = 14'h0400;
    logic        clk, rst_n, tick, awvalid, wvalid, bready, arvalid, rready;
    lcdd_osc_t   osc;
    logic [13:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb, con;
    logic        awready, wready, bvalid, arready, rvalid, sup, refs, multi;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] com, seen;
    logic [63:0] seg;
    logic [3:0]  mem [256];
    int          num_errors, comparisons;

    lcdd_top i_lcdd_top (.i_clk(clk), .i_rst_n(rst_n), .i_lsclk_tick(tick), .i_osc_sel(osc),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready), .o_common_outputs(com), .o_segment_outputs(seg),
        .o_lcd_supply_on(sup), .o_reference_level_select(refs), .o_contrast_code(con));
    lcdd_panel_model i_lcdd_panel_model (.i_clk(clk), .i_common_outputs(com), .o_frame_seen(seen),
        .o_multi_common(multi));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // low-speed tick every second cycle
    always @(posedge clk) tick <= rst_n ? !tick : 1'b0;

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic limit(input int n, input int max);
        if (n >= max) begin
            num_errors++;
            $display("[FAIL] wait limit expected below %0d seen %0d", max, n);
            finish_test();
        end
    endtask
    // ****************************************
    // bus master
    // ****************************************
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        int n;
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        n = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) begin ad = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready) begin wd = 1'b1; wvalid <= 1'b0; end
        end while (!(ad && wd) && n < 50);
        do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 50);
        limit(n, 50);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [13:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 50);
        limit(n, 50);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    function automatic logic [63:0] row_of(input int c);
        for (int s = 0; s < 64; s++) row_of[s] = mem[c * 16 + s / 4][s % 4];
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        logic [13:0] a [3] = '{A_D0, A_D1, A_D2};
        foreach (a[i]) begin rdr(a[i]); chk("reset word", 64'h0, rd); end
        rdr(A_BAD);
        chk("unmapped", {RESP_SLVERR, 32'h0}, {rsp, rd});
        chk("outputs off", 64'h0, {com, seg[47:0]} | seg);
    endtask
    task automatic t_mem;
        for (int i = 0; i < 256; i++) begin mem[i] = 4'(i * 5 + 1); wr(A_MEM + 14'(i * 4), 32'(mem[i])); end
        for (int i = 0; i < 256; i++) begin rdr(A_MEM + 14'(i * 4)); chk("memory", 64'(mem[i]), rd); end
    endtask
    task automatic t_ctrl;
        wr(A_D0, 32'hF); rdr(A_D0); chk("supply word", 64'hD, rd);
        chk("ref and supply", 64'h3, {refs, sup});
        wr(A_D0, 32'h0); @(posedge clk); chk("ref and supply off", 64'h0, {refs, sup});
        wr(A_D1, 32'hF); rdr(A_D1); chk("force word", 64'h6, rd);
        for (int c = 0; c < 16; c++) begin
            wr(A_D2, 32'(c)); rdr(A_D2); chk("contrast", 64'(c * 17), {rd[3:0], con});
        end
        wr(A_D2, 32'h3, 4'h0); rdr(A_D2); chk("strobe off", 64'hF, rd);
        wr(A_D2, 32'h7);
    endtask
    task automatic t_force;
        logic [63:0] e [3] = '{'1, '0, '1};
        wr(A_D0, 32'h1);
        repeat (8) @(posedge clk);
        for (int v = 1; v < 4; v++) begin
            wr(A_D1, 32'(v * 2)); repeat (4) @(posedge clk); chk("forced segs", e[v - 1], seg);
        end
        wr(A_D1, 32'h0);
    endtask
    task automatic t_scan(input logic d8, input lcdd_osc_t o, input logic [15:0] exp, input int tk, input bit rows);
        int n, st, c;
        logic p;
        logic [15:0] pc;
        @(posedge clk);
        osc <= o;
        wr(A_D0, {28'h0, d8, 3'b001});
        n = 0;
        p = 1'b1;
        do begin @(posedge clk); n++; p = com[0] && !p ? 1'b0 : com[0]; end while (p !== 1'b0 && n < 20000);
        limit(n, 20000);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            st = 0;
            do begin
                @(posedge clk);
                n++;
                st = (pc === com) ? st + 1 : 0;
                pc = com;
                for (int i = 0; i < 16; i++) if (com[i]) c = i;
                if (rows && st == 4) chk("row", row_of(c), seg);
                if (com[0] && !p) break;
                p = com[0];
            end while (n < 10000);
            p = com[0];
        end
        chk("frame cycles", 64'(2 * tk), 64'(n));
        @(posedge clk);
        chk("commons in frame", {15'h0, 1'b0, exp}, {15'h0, multi, seen});
    endtask

    initial begin
        num_errors = 0; comparisons = 0; rst_n = 1'b0; osc = LCDD_OSC_32K768;
        awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_mem();
        t_ctrl();
        t_force();
        t_scan(1'b0, LCDD_OSC_32K768, 16'hFFFF, 1024, 1'b1);
        t_scan(1'b0, LCDD_OSC_38K4, 16'hFFFF, 1024, 1'b0);
        t_scan(1'b0, LCDD_OSC_50K, 16'hFFFF, 1600, 1'b0);
        t_scan(1'b0, LCDD_OSC_76K8, 16'hFFFF, 2048, 1'b0);
        t_scan(1'b1, LCDD_OSC_32K768, 16'h00FF, 1024, 1'b1);
        wr(A_D0, 32'h0);
        repeat (4) @(posedge clk);
        chk("supply off", 64'h0, {48'h0, com} | seg);
        finish_test();
    end
endmodule
`default_nettype wire
